// >>> design/lcd_cmd_pkg.sv
// constants for the lcd power and mode command decoder
// How it works
// - byte 0xee written as command leaves read-modify-write cursor mode
// - leaving that mode reloads column counter with value saved on entry
// - soft reset 0xe2 restores start line, column, page, scan direction; ram kept
// - soft reset leaves power settings alone; only hardware reset clears them
// - byte 1100xxxx latches bit 3 as common scan reverse
// - byte 00101xxx loads converter, regulator and follower enables
// - byte 00100xxx loads regulator ratio code, default 100
// - byte 0x81 arms contrast; next byte loads contrast and disarms
// - contrast takes low six bits of second byte, default 32
// - byte 1010110x sets static indicator mode from bit 0
// - with indicator mode on, next byte is indicator data, then normal decoding
// - indicator output: off, slow blink, fast blink, steady from two bits
// - test opcodes 1111xxxx, 1001xxxx set test state, cleared by either reset
// - all-pixels-on while display off enters power save instead
// - power save picks standby if indicator mode on, else sleep
// - all-pixels-on with bit 0 clear leaves power save
// - sleep stops oscillator, power circuits and drivers, outputs grounded
// - standby stops power circuits and drivers, keeps oscillator for indicator
// - soft reset in standby moves to sleep
// - in read-modify-write mode reads hold the column, writes still advance it
// - byte 1010010x sets all pixels on from bit 0
package lcd_cmd_pkg;
  localparam logic [7:0] CMD_RMW_SET    = 8'he0;
  localparam logic [7:0] CMD_RMW_END    = 8'hee;
  localparam logic [7:0] CMD_SOFT_RESET = 8'he2;
  localparam logic [7:0] CMD_CONTRAST   = 8'h81;
  localparam logic [7:0] CMD_DISP_OFF   = 8'hae;
  localparam logic [7:0] CMD_DISP_ON    = 8'haf;
  localparam logic [3:0] GRP_SCAN       = 4'hc;
  localparam logic [3:0] GRP_TEST_A     = 4'hf;
  localparam logic [3:0] GRP_TEST_B     = 4'h9;
  localparam logic [4:0] GRP_POWER      = 5'h05;
  localparam logic [4:0] GRP_RATIO      = 5'h04;
  localparam logic [6:0] GRP_INDICATOR  = 7'h56;
  localparam logic [6:0] GRP_ALL_ON     = 7'h52;
  localparam logic [3:0] GRP_COL_MSB    = 4'h1;
  localparam logic [3:0] GRP_COL_LSB    = 4'h0;
  localparam logic [3:0] GRP_PAGE       = 4'hb;
  localparam logic [1:0] GRP_START_LINE = 2'h1;
  localparam int         SCAN_BIT       = 3;
  localparam logic [2:0] RATIO_RESET    = 3'h4;
  localparam logic [5:0] CONTRAST_RESET = 6'h20;
  localparam logic [2:0] POWER_RESET    = 3'h0;
  localparam logic [7:0] COLUMN_RESET   = 8'h00;
  localparam logic [3:0] PAGE_RESET     = 4'h0;
  localparam logic [5:0] LINE_RESET     = 6'h00;
  localparam int         CLK_HZ         = 100000000;
  localparam int         SLOW_BLINK_MS  = 1000;
  localparam int         FAST_BLINK_MS  = 500;
  localparam int         SLOW_HALF_CYC  = CLK_HZ / 1000 * SLOW_BLINK_MS / 2;
  localparam int         FAST_HALF_CYC  = CLK_HZ / 1000 * FAST_BLINK_MS / 2;
  localparam logic [1:0] IND_OFF        = 2'h0;
  localparam logic [1:0] IND_SLOW       = 2'h1;
  localparam logic [1:0] IND_FAST       = 2'h2;
  localparam logic [1:0] IND_STEADY     = 2'h3;
  typedef enum logic [1:0] {
    PS_RUN     = 2'b00,
    PS_STANDBY = 2'b01,
    PS_SLEEP   = 2'b11
  } power_state_t;
  typedef enum logic [1:0] {
    PEND_NONE      = 2'b00,
    PEND_CONTRAST  = 2'b01,
    PEND_INDICATOR = 2'b11
  } pending_t;
endpackage : lcd_cmd_pkg

// >>> design/lcd_column_counter.sv
// column address counter with read-modify-write save and restore
`timescale 1ns/1ps
module lcd_column_counter (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       load_msb_in,
  input  wire logic       load_lsb_in,
  input  wire logic [3:0] nibble_in,
  input  wire logic       clear_in,
  input  wire logic       rmw_enter_in,
  input  wire logic       rmw_exit_in,
  input  wire logic       rmw_active_in,
  input  wire logic       data_read_in,
  input  wire logic       data_write_in,
  output logic      [7:0] column_out
);
  logic [7:0] column;
  logic [7:0] saved;
  logic [7:0] next_column;
  logic [7:0] next_saved;

  always_comb begin
    next_column = column;
    next_saved  = saved;
    if (rmw_enter_in) begin
      next_saved = column;
    end
    if (clear_in) begin
      next_column = lcd_cmd_pkg::COLUMN_RESET;
    end else if (rmw_exit_in) begin
      next_column = saved;
    end else if (load_msb_in) begin
      next_column = {nibble_in, column[3:0]};
    end else if (load_lsb_in) begin
      next_column = {column[7:4], nibble_in};
    end else if (data_write_in || (data_read_in && !rmw_active_in)) begin
      next_column = 8'(column + 8'h01);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      column <= lcd_cmd_pkg::COLUMN_RESET;
      saved  <= lcd_cmd_pkg::COLUMN_RESET;
    end else begin
      column <= next_column;
      saved  <= next_saved;
    end
  end

  assign column_out = column;
endmodule : lcd_column_counter

// >>> design/lcd_indicator_blinker.sv
// static indicator drive with two blink rates
`timescale 1ns/1ps
module lcd_indicator_blinker #(
  parameter int SLOW_HALF = lcd_cmd_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = lcd_cmd_pkg::FAST_HALF_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       osc_run_in,
  input  wire logic [1:0] pattern_in,
  output logic            drive_out
);
  initial begin
    if (FAST_HALF < 1 || SLOW_HALF < FAST_HALF) begin
      $error("blink half periods must be positive and slow not below fast");
    end
  end

  logic [31:0] count;
  logic        phase;
  logic        drive;
  logic [31:0] next_count;
  logic        next_phase;
  logic        next_drive;
  logic [31:0] half;

  always_comb begin
    half       = (pattern_in == lcd_cmd_pkg::IND_FAST) ? 32'(FAST_HALF) : 32'(SLOW_HALF);
    next_count = count;
    next_phase = phase;
    // oscillator stopped freezes the blink phase; sleep also forces the pin low
    if (osc_run_in) begin
      if (count >= half - 32'h1) begin
        next_count = 32'h0;
        next_phase = !phase;
      end else begin
        next_count = 32'(count + 32'h1);
      end
    end
    unique case (pattern_in)
      lcd_cmd_pkg::IND_OFF:    next_drive = 1'b0;
      lcd_cmd_pkg::IND_SLOW:   next_drive = phase;
      lcd_cmd_pkg::IND_FAST:   next_drive = phase;
      lcd_cmd_pkg::IND_STEADY: next_drive = 1'b1;
    endcase
    if (!osc_run_in) begin
      next_drive = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count <= 32'h0;
      phase <= 1'b0;
      drive <= 1'b0;
    end else begin
      count <= next_count;
      phase <= next_phase;
      drive <= next_drive;
    end
  end

  assign drive_out = drive;
endmodule : lcd_indicator_blinker

// >>> design/lcd_power_mode_command_decoder.sv
// command decoder for power, scan, contrast, indicator and power save
`timescale 1ns/1ps
module lcd_power_mode_command_decoder #(
  parameter int SLOW_HALF = lcd_cmd_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = lcd_cmd_pkg::FAST_HALF_CYC
) (
  input  wire logic       CLK_IN,
  input  wire logic       RESETN_IN,
  input  wire logic       STROBE_IN,
  input  wire logic       REGISTER_SELECT_IN,
  input  wire logic       READ_NOT_WRITE_IN,
  input  wire logic [7:0] DATA_IN,
  output logic            RMW_ACTIVE_OUT,
  output logic      [7:0] COLUMN_OUT,
  output logic      [3:0] PAGE_OUT,
  output logic      [5:0] START_LINE_OUT,
  output logic            COM_SCAN_REVERSE_OUT,
  output logic            CONVERTER_ENABLE_OUT,
  output logic            REGULATOR_ENABLE_OUT,
  output logic            FOLLOWER_ENABLE_OUT,
  output logic      [2:0] RATIO_OUT,
  output logic      [5:0] CONTRAST_OUT,
  output logic            CONTRAST_PENDING_OUT,
  output logic            INDICATOR_MODE_ON_OUT,
  output logic            INDICATOR_PENDING_OUT,
  output logic      [1:0] INDICATOR_BLINK_OUT,
  output logic            INDICATOR_DRIVE_OUT,
  output logic            TEST_STATE_OUT,
  output logic            DISPLAY_ON_OUT,
  output logic            ALL_PIXELS_ON_OUT,
  output logic            STANDBY_OUT,
  output logic            SLEEP_OUT,
  output logic            OSC_RUN_OUT,
  output logic            POWER_CIRCUITS_RUN_OUT,
  output logic            DRIVERS_RUN_OUT
);
  // ==========================================================
  // byte classification
  // ==========================================================
  logic cmd_write;
  logic data_write;
  logic data_read;
  logic [7:0] b;

  assign b          = DATA_IN;
  assign cmd_write  = STROBE_IN && !REGISTER_SELECT_IN && !READ_NOT_WRITE_IN;
  assign data_write = STROBE_IN && REGISTER_SELECT_IN && !READ_NOT_WRITE_IN;
  assign data_read  = STROBE_IN && REGISTER_SELECT_IN && READ_NOT_WRITE_IN;

  // ==========================================================
  // state
  // ==========================================================
  lcd_cmd_pkg::pending_t     pending;
  lcd_cmd_pkg::power_state_t pstate;
  logic       rmw;
  logic [3:0] page;
  logic [5:0] line;
  logic       scan_rev;
  logic [2:0] power;
  logic [2:0] ratio;
  logic [5:0] contrast;
  logic       ind_mode;
  logic [1:0] ind_pat;
  logic       test;
  logic       disp_on;
  logic       all_on;

  lcd_cmd_pkg::pending_t     next_pending;
  lcd_cmd_pkg::power_state_t next_pstate;
  logic       next_rmw;
  logic [3:0] next_page;
  logic [5:0] next_line;
  logic       next_scan_rev;
  logic [2:0] next_power;
  logic [2:0] next_ratio;
  logic [5:0] next_contrast;
  logic       next_ind_mode;
  logic [1:0] next_ind_pat;
  logic       next_test;
  logic       next_disp_on;
  logic       next_all_on;

  logic opcode;
  logic soft_reset;
  logic rmw_enter;
  logic rmw_exit;
  logic col_msb;
  logic col_lsb;

  // a byte following an arming byte is data, never an opcode
  assign opcode     = cmd_write && pending == lcd_cmd_pkg::PEND_NONE;
  assign soft_reset = opcode && b == lcd_cmd_pkg::CMD_SOFT_RESET;
  assign rmw_enter  = opcode && b == lcd_cmd_pkg::CMD_RMW_SET;
  assign rmw_exit   = opcode && b == lcd_cmd_pkg::CMD_RMW_END && rmw;
  assign col_msb    = opcode && b[7:4] == lcd_cmd_pkg::GRP_COL_MSB;
  assign col_lsb    = opcode && b[7:4] == lcd_cmd_pkg::GRP_COL_LSB;

  // ==========================================================
  // decode
  // ==========================================================
  always_comb begin
    next_pending  = pending;
    next_pstate   = pstate;
    next_rmw      = rmw;
    next_page     = page;
    next_line     = line;
    next_scan_rev = scan_rev;
    next_power    = power;
    next_ratio    = ratio;
    next_contrast = contrast;
    next_ind_mode = ind_mode;
    next_ind_pat  = ind_pat;
    next_test     = test;
    next_disp_on  = disp_on;
    next_all_on   = all_on;
    if (cmd_write && pending == lcd_cmd_pkg::PEND_CONTRAST) begin
      next_contrast = b[5:0];
      next_pending  = lcd_cmd_pkg::PEND_NONE;
    end else if (cmd_write && pending == lcd_cmd_pkg::PEND_INDICATOR) begin
      next_ind_pat = b[1:0];
      next_pending = lcd_cmd_pkg::PEND_NONE;
    end else if (opcode) begin
      if (b == lcd_cmd_pkg::CMD_RMW_SET) begin
        next_rmw = 1'b1;
      end else if (b == lcd_cmd_pkg::CMD_RMW_END) begin
        next_rmw = 1'b0;
      end else if (b == lcd_cmd_pkg::CMD_SOFT_RESET) begin
        // power, ratio and contrast are left as they are
        next_line     = lcd_cmd_pkg::LINE_RESET;
        next_page     = lcd_cmd_pkg::PAGE_RESET;
        next_scan_rev = 1'b0;
        next_test     = 1'b0;
        if (pstate == lcd_cmd_pkg::PS_STANDBY) begin
          next_pstate = lcd_cmd_pkg::PS_SLEEP;
        end
      end else if (b == lcd_cmd_pkg::CMD_CONTRAST) begin
        next_pending = lcd_cmd_pkg::PEND_CONTRAST;
      end else if (b == lcd_cmd_pkg::CMD_DISP_OFF) begin
        next_disp_on = 1'b0;
      end else if (b == lcd_cmd_pkg::CMD_DISP_ON) begin
        next_disp_on = 1'b1;
      end else if (b[7:1] == lcd_cmd_pkg::GRP_INDICATOR) begin
        next_ind_mode = b[0];
        if (b[0]) begin
          next_pending = lcd_cmd_pkg::PEND_INDICATOR;
        end
      end else if (b[7:1] == lcd_cmd_pkg::GRP_ALL_ON) begin
        if (b[0] && !disp_on) begin
          // pixels are not lit; the byte becomes a power save request
          next_pstate = ind_mode ? lcd_cmd_pkg::PS_STANDBY : lcd_cmd_pkg::PS_SLEEP;
        end else begin
          next_all_on = b[0];
          if (!b[0]) begin
            next_pstate = lcd_cmd_pkg::PS_RUN;
          end
        end
      end else if (b[7:4] == lcd_cmd_pkg::GRP_SCAN) begin
        next_scan_rev = b[lcd_cmd_pkg::SCAN_BIT];
      end else if (b[7:4] == lcd_cmd_pkg::GRP_TEST_A || b[7:4] == lcd_cmd_pkg::GRP_TEST_B) begin
        next_test = 1'b1;
      end else if (b[7:3] == lcd_cmd_pkg::GRP_POWER) begin
        next_power = b[2:0];
      end else if (b[7:3] == lcd_cmd_pkg::GRP_RATIO) begin
        next_ratio = b[2:0];
      end else if (b[7:4] == lcd_cmd_pkg::GRP_PAGE) begin
        next_page = b[3:0];
      end else if (b[7:6] == lcd_cmd_pkg::GRP_START_LINE) begin
        next_line = b[5:0];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      pending  <= lcd_cmd_pkg::PEND_NONE;
      pstate   <= lcd_cmd_pkg::PS_RUN;
      rmw      <= 1'b0;
      page     <= lcd_cmd_pkg::PAGE_RESET;
      line     <= lcd_cmd_pkg::LINE_RESET;
      scan_rev <= 1'b0;
      power    <= lcd_cmd_pkg::POWER_RESET;
      ratio    <= lcd_cmd_pkg::RATIO_RESET;
      contrast <= lcd_cmd_pkg::CONTRAST_RESET;
      ind_mode <= 1'b0;
      ind_pat  <= lcd_cmd_pkg::IND_OFF;
      test     <= 1'b0;
      disp_on  <= 1'b0;
      all_on   <= 1'b0;
    end else begin
      pending  <= next_pending;
      pstate   <= next_pstate;
      rmw      <= next_rmw;
      page     <= next_page;
      line     <= next_line;
      scan_rev <= next_scan_rev;
      power    <= next_power;
      ratio    <= next_ratio;
      contrast <= next_contrast;
      ind_mode <= next_ind_mode;
      ind_pat  <= next_ind_pat;
      test     <= next_test;
      disp_on  <= next_disp_on;
      all_on   <= next_all_on;
    end
  end

  // ==========================================================
  // column counter and indicator
  // ==========================================================
  logic osc_run;
  logic run;

  assign run     = pstate == lcd_cmd_pkg::PS_RUN;
  assign osc_run = pstate != lcd_cmd_pkg::PS_SLEEP;

  lcd_column_counter u_column (
    .clk_in        (CLK_IN),
    .rst_n_in      (RESETN_IN),
    .load_msb_in   (col_msb),
    .load_lsb_in   (col_lsb),
    .nibble_in     (b[3:0]),
    .clear_in      (soft_reset),
    .rmw_enter_in  (rmw_enter),
    .rmw_exit_in   (rmw_exit),
    .rmw_active_in (rmw),
    .data_read_in  (data_read),
    .data_write_in (data_write),
    .column_out    (COLUMN_OUT)
  );

  lcd_indicator_blinker #(
    .SLOW_HALF (SLOW_HALF),
    .FAST_HALF (FAST_HALF)
  ) u_blink (
    .clk_in     (CLK_IN),
    .rst_n_in   (RESETN_IN),
    .osc_run_in (osc_run),
    .pattern_in (ind_pat),
    .drive_out  (INDICATOR_DRIVE_OUT)
  );

  // ==========================================================
  // outputs
  // ==========================================================
  assign RMW_ACTIVE_OUT         = rmw;
  assign PAGE_OUT               = page;
  assign START_LINE_OUT         = line;
  assign COM_SCAN_REVERSE_OUT   = scan_rev;
  // power circuits are gated off in both save states, register kept
  assign CONVERTER_ENABLE_OUT   = power[2] && run;
  assign REGULATOR_ENABLE_OUT   = power[1] && run;
  assign FOLLOWER_ENABLE_OUT    = power[0] && run;
  assign RATIO_OUT              = ratio;
  assign CONTRAST_OUT           = contrast;
  assign CONTRAST_PENDING_OUT   = pending == lcd_cmd_pkg::PEND_CONTRAST;
  assign INDICATOR_MODE_ON_OUT  = ind_mode;
  assign INDICATOR_PENDING_OUT  = pending == lcd_cmd_pkg::PEND_INDICATOR;
  assign INDICATOR_BLINK_OUT    = ind_pat;
  assign TEST_STATE_OUT         = test;
  assign DISPLAY_ON_OUT         = disp_on;
  assign ALL_PIXELS_ON_OUT      = all_on;
  assign STANDBY_OUT            = pstate == lcd_cmd_pkg::PS_STANDBY;
  assign SLEEP_OUT              = pstate == lcd_cmd_pkg::PS_SLEEP;
  assign OSC_RUN_OUT            = osc_run;
  assign POWER_CIRCUITS_RUN_OUT = run;
  assign DRIVERS_RUN_OUT        = run;
endmodule : lcd_power_mode_command_decoder

// >>> tb/lcd_host_model.sv
// host side model issuing instruction and display data bytes
`timescale 1ns/1ps
module lcd_host_model (
  input  wire logic       clk_in,
  output logic            strobe_out,
  output logic            rs_out,
  output logic            rw_out,
  output logic      [7:0] data_out
);
  initial begin
    strobe_out = 1'b0;
    rs_out     = 1'b1;
    rw_out     = 1'b1;
    data_out   = 8'h00;
  end
  // ==========================================================
  // byte cycle
  // one whole byte per strobe; the second byte of a pair is just the next call
  task automatic send(input logic rs, input logic rw, input logic [7:0] d);
    @(negedge clk_in);
    strobe_out = 1'b1;
    rs_out     = rs;
    rw_out     = rw;
    data_out   = d;
    @(negedge clk_in);
    strobe_out = 1'b0;
    // released bus shows the inverse so a stale byte is never mistaken for a live one
    data_out   = ~d;
  endtask : send
endmodule : lcd_host_model

// >>> tb/lcd_cmd_asserts.sv
// concurrent checks on the command decoder ports
`timescale 1ns/1ps
module lcd_cmd_asserts (
  input wire logic       CLK_IN,
  input wire logic       RESETN_IN,
  input wire logic       STROBE_IN,
  input wire logic       REGISTER_SELECT_IN,
  input wire logic       READ_NOT_WRITE_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic       RMW_ACTIVE_OUT,
  input wire logic [7:0] COLUMN_OUT,
  input wire logic       COM_SCAN_REVERSE_OUT,
  input wire logic       CONVERTER_ENABLE_OUT,
  input wire logic       REGULATOR_ENABLE_OUT,
  input wire logic       FOLLOWER_ENABLE_OUT,
  input wire logic [2:0] RATIO_OUT,
  input wire logic [5:0] CONTRAST_OUT,
  input wire logic       CONTRAST_PENDING_OUT,
  input wire logic       INDICATOR_MODE_ON_OUT,
  input wire logic       INDICATOR_PENDING_OUT,
  input wire logic       TEST_STATE_OUT,
  input wire logic       DISPLAY_ON_OUT,
  input wire logic       ALL_PIXELS_ON_OUT,
  input wire logic       STANDBY_OUT,
  input wire logic       SLEEP_OUT,
  input wire logic       OSC_RUN_OUT,
  input wire logic       POWER_CIRCUITS_RUN_OUT,
  input wire logic       DRIVERS_RUN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ==========================================================
  // helper logic
  logic       cmd;
  logic       run;
  logic [7:0] saved;
  logic [7:0] next_saved;
  assign cmd = STROBE_IN && !REGISTER_SELECT_IN && !READ_NOT_WRITE_IN && !CONTRAST_PENDING_OUT
               && !INDICATOR_PENDING_OUT;
  assign run = !STANDBY_OUT && !SLEEP_OUT;
  always_comb next_saved = (cmd && DATA_IN == 8'he0) ? COLUMN_OUT : saved;
  always_ff @(posedge CLK_IN) saved <= next_saved;
  // ==========================================================
  // properties
  property p_scan; cmd && DATA_IN[7:4] == 4'hc |=> COM_SCAN_REVERSE_OUT == $past(DATA_IN[3]); endproperty
  a_scan: assert property (p_scan) else $error("scan bit not latched");
  property p_power; cmd && DATA_IN[7:3] == 5'h05 && run
    |=> {CONVERTER_ENABLE_OUT, REGULATOR_ENABLE_OUT, FOLLOWER_ENABLE_OUT} == $past(DATA_IN[2:0]); endproperty
  a_power: assert property (p_power) else $error("power enables wrong");
  property p_ratio; cmd && DATA_IN[7:3] == 5'h04 |=> RATIO_OUT == $past(DATA_IN[2:0]); endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_contrast; STROBE_IN && !REGISTER_SELECT_IN && !READ_NOT_WRITE_IN && CONTRAST_PENDING_OUT
    |=> CONTRAST_OUT == $past(DATA_IN[5:0]) && !CONTRAST_PENDING_OUT; endproperty
  a_contrast: assert property (p_contrast) else $error("contrast load wrong");
  property p_data_not_cmd; STROBE_IN && REGISTER_SELECT_IN |=> $stable(RATIO_OUT) && $stable(COM_SCAN_REVERSE_OUT);
  endproperty
  a_data_not_cmd: assert property (p_data_not_cmd) else $error("data byte decoded");
  property p_rmw_exit; cmd && DATA_IN == 8'hee && RMW_ACTIVE_OUT |=> !RMW_ACTIVE_OUT && COLUMN_OUT == saved;
  endproperty
  a_rmw_exit: assert property (p_rmw_exit) else $error("column not restored");
  property p_rmw_read; STROBE_IN && REGISTER_SELECT_IN && READ_NOT_WRITE_IN && RMW_ACTIVE_OUT
    |=> $stable(COLUMN_OUT); endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("read moved column");
  property p_save_entry; cmd && DATA_IN == 8'ha5 && !DISPLAY_ON_OUT && run
    |=> STANDBY_OUT == $past(INDICATOR_MODE_ON_OUT) && SLEEP_OUT != $past(INDICATOR_MODE_ON_OUT)
    && !ALL_PIXELS_ON_OUT; endproperty
  a_save_entry: assert property (p_save_entry) else $error("power save entry wrong");
  property p_save_exit; cmd && DATA_IN == 8'ha4 |=> run; endproperty
  a_save_exit: assert property (p_save_exit) else $error("power save not left");
  property p_sleep; SLEEP_OUT |-> !OSC_RUN_OUT && !POWER_CIRCUITS_RUN_OUT && !DRIVERS_RUN_OUT; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
  property p_standby; STANDBY_OUT |-> OSC_RUN_OUT && !POWER_CIRCUITS_RUN_OUT && !DRIVERS_RUN_OUT
    && !CONVERTER_ENABLE_OUT; endproperty
  a_standby: assert property (p_standby) else $error("standby outputs wrong");
  property p_reset_cmd; cmd && DATA_IN == 8'he2 |=> !TEST_STATE_OUT && (SLEEP_OUT || !$past(STANDBY_OUT));
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("soft reset effect wrong");
  c_standby: cover property (cmd && DATA_IN == 8'ha5 ##1 STANDBY_OUT);
  c_sleep: cover property (STANDBY_OUT ##1 SLEEP_OUT);
  c_contrast: cover property (CONTRAST_PENDING_OUT ##1 !CONTRAST_PENDING_OUT);
endmodule : lcd_cmd_asserts

// >>> tb/lcd_power_mode_command_decoder_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
module lcd_power_mode_command_decoder_tb;
  logic clk, rst_n, stb, rs, rw, s0, s1;
  logic [7:0] dat;
  int failures, total_checks;
  lcd_host_model u_lcd_host_model (.clk_in(clk), .strobe_out(stb), .rs_out(rs), .rw_out(rw), .data_out(dat));
  lcd_power_mode_command_decoder #(.SLOW_HALF(4), .FAST_HALF(2)) u_lcd_power_mode_command_decoder (
    .CLK_IN(clk), .RESETN_IN(rst_n), .STROBE_IN(stb), .REGISTER_SELECT_IN(rs), .READ_NOT_WRITE_IN(rw),
    .DATA_IN(dat), .RMW_ACTIVE_OUT(), .COLUMN_OUT(), .PAGE_OUT(), .START_LINE_OUT(), .COM_SCAN_REVERSE_OUT(),
    .CONVERTER_ENABLE_OUT(), .REGULATOR_ENABLE_OUT(), .FOLLOWER_ENABLE_OUT(), .RATIO_OUT(), .CONTRAST_OUT(),
    .CONTRAST_PENDING_OUT(), .INDICATOR_MODE_ON_OUT(), .INDICATOR_PENDING_OUT(), .INDICATOR_BLINK_OUT(),
    .INDICATOR_DRIVE_OUT(), .TEST_STATE_OUT(), .DISPLAY_ON_OUT(), .ALL_PIXELS_ON_OUT(), .STANDBY_OUT(),
    .SLEEP_OUT(), .OSC_RUN_OUT(), .POWER_CIRCUITS_RUN_OUT(), .DRIVERS_RUN_OUT());
  `define D u_lcd_power_mode_command_decoder
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic cmd(input logic [7:0] d); u_lcd_host_model.send(1'b0, 1'b0, d); endtask : cmd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // sample the indicator pin long enough to see both levels of the fast blink
  task automatic watch_pin;
    s0 = 1'b0;
    s1 = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (`D.INDICATOR_DRIVE_OUT === 1'b1) s1 = 1'b1;
      if (`D.INDICATOR_DRIVE_OUT === 1'b0) s0 = 1'b1;
    end
  endtask : watch_pin
  // ==========================================================
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #100us;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk(`D.RATIO_OUT, lcd_cmd_pkg::RATIO_RESET);
    chk(`D.CONTRAST_OUT, lcd_cmd_pkg::CONTRAST_RESET);
    for (int i = 0; i < 8; i++) begin
      cmd(8'h28 | i[7:0]);
      chk({`D.CONVERTER_ENABLE_OUT, `D.REGULATOR_ENABLE_OUT, `D.FOLLOWER_ENABLE_OUT}, i[7:0]);
      cmd(8'h20 | i[7:0]);
      chk(`D.RATIO_OUT, i[7:0]);
    end
    cmd(8'h22);
    cmd(8'hcf);
    chk(`D.COM_SCAN_REVERSE_OUT, 8'h01);
    cmd(8'h81);
    chk(`D.CONTRAST_PENDING_OUT, 8'h01);
    cmd(8'hff);
    chk({`D.CONTRAST_PENDING_OUT, `D.CONTRAST_OUT}, 8'h3f);
    cmd(8'h81);
    cmd(8'hc0);
    chk({`D.COM_SCAN_REVERSE_OUT, `D.CONTRAST_OUT}, 8'h40);
    $display("test power ratio contrast done");
    cmd(8'h13);
    cmd(8'h05);
    cmd(8'hb3);
    cmd(8'h45);
    chk(`D.START_LINE_OUT, 8'h05);
    cmd(8'hf0);
    chk(`D.TEST_STATE_OUT, 8'h01);
    u_lcd_host_model.send(1'b1, 1'b0, 8'he2);
    chk({`D.COLUMN_OUT[6:0], `D.COM_SCAN_REVERSE_OUT}, 8'h6d);
    cmd(8'he2);
    chk(`D.COLUMN_OUT, 8'h00);
    chk({`D.START_LINE_OUT, `D.TEST_STATE_OUT, `D.COM_SCAN_REVERSE_OUT}, 8'h00);
    chk(`D.PAGE_OUT, 8'h00);
    chk({`D.RATIO_OUT, `D.CONVERTER_ENABLE_OUT, `D.REGULATOR_ENABLE_OUT, `D.FOLLOWER_ENABLE_OUT}, 8'h17);
    chk(`D.CONTRAST_OUT, 8'h00);
    cmd(8'h90);
    cmd(8'he2);
    chk(`D.TEST_STATE_OUT, 8'h00);
    $display("test soft reset done");
    cmd(8'h11);
    cmd(8'h02);
    cmd(8'he0);
    u_lcd_host_model.send(1'b1, 1'b0, 8'h55);
    u_lcd_host_model.send(1'b1, 1'b1, 8'h00);
    chk(`D.COLUMN_OUT, 8'h13);
    u_lcd_host_model.send(1'b1, 1'b0, 8'haa);
    chk(`D.COLUMN_OUT, 8'h14);
    cmd(8'hee);
    chk({`D.RMW_ACTIVE_OUT, `D.COLUMN_OUT[6:0]}, 8'h12);
    $display("test modify read done");
    for (int i = 0; i < 4; i++) begin
      cmd(8'had);
      chk({`D.INDICATOR_MODE_ON_OUT, `D.INDICATOR_PENDING_OUT}, 8'h03);
      cmd(8'hfc | i[7:0]);
      chk({`D.INDICATOR_PENDING_OUT, `D.TEST_STATE_OUT, `D.INDICATOR_BLINK_OUT}, i[7:0]);
      repeat (2) @(negedge clk);
      if (i == 0 || i == 3) chk(`D.INDICATOR_DRIVE_OUT, {7'h0, i[0]});
    end
    cmd(8'had);
    cmd(8'h02);
    cmd(8'ha5);
    chk({`D.STANDBY_OUT, `D.SLEEP_OUT}, 8'h02);
    chk({`D.OSC_RUN_OUT, `D.DRIVERS_RUN_OUT, `D.CONVERTER_ENABLE_OUT}, 8'h04);
    watch_pin();
    chk({s1, s0}, 8'h03);
    cmd(8'he2);
    chk({`D.STANDBY_OUT, `D.SLEEP_OUT, `D.OSC_RUN_OUT, `D.POWER_CIRCUITS_RUN_OUT}, 8'h04);
    repeat (2) @(negedge clk);
    chk(`D.INDICATOR_DRIVE_OUT, 8'h00);
    cmd(8'ha4);
    chk({`D.SLEEP_OUT, `D.POWER_CIRCUITS_RUN_OUT, `D.CONVERTER_ENABLE_OUT}, 8'h03);
    cmd(8'hac);
    cmd(8'ha5);
    chk({`D.STANDBY_OUT, `D.SLEEP_OUT, `D.INDICATOR_PENDING_OUT}, 8'h02);
    cmd(8'ha4);
    cmd(8'haf);
    chk(`D.DISPLAY_ON_OUT, 8'h01);
    cmd(8'ha5);
    chk({`D.ALL_PIXELS_ON_OUT, `D.SLEEP_OUT, `D.STANDBY_OUT}, 8'h04);
    cmd(8'ha4);
    chk(`D.ALL_PIXELS_ON_OUT, 8'h00);
    cmd(8'hae);
    cmd(8'ha5);
    chk({`D.DISPLAY_ON_OUT, `D.SLEEP_OUT, `D.ALL_PIXELS_ON_OUT}, 8'h02);
    cmd(8'ha4);
    $display("test power save done");
    // hardware reset is the only way back to the power defaults
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    chk({`D.RATIO_OUT, `D.CONVERTER_ENABLE_OUT, `D.REGULATOR_ENABLE_OUT, `D.FOLLOWER_ENABLE_OUT}, 8'h20);
    chk({`D.CONTRAST_OUT, `D.SLEEP_OUT}, 8'h40);
    $display("test hardware reset done");
    wrap_up();
  end
endmodule : lcd_power_mode_command_decoder_tb
bind lcd_power_mode_command_decoder lcd_cmd_asserts u_lcd_cmd_asserts (.*);
